//--- logic/per_sample_gain_offset_correction.sv
// per-sample gain and offset correction for converters 3 and 4
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/100ps
module per_sample_gain_offset_correction (
   input  wire logic                                 clk,
   input  wire logic                                 rst,
   input  wire logic [gain_offset_pkg::ADDR_W-1:0]   reg_addr,
   input  wire logic [gain_offset_pkg::DATA_W-1:0]   reg_wdata,
   input  wire logic                                 reg_wr,
   input  wire logic                                 reg_rd,
   output logic      [gain_offset_pkg::DATA_W-1:0]   reg_rdata,
   input  wire logic [gain_offset_pkg::SAMPLE_W-1:0] conv3_sample_in,
   input  wire logic                                 conv3_valid_in,
   input  wire logic [gain_offset_pkg::SAMPLE_W-1:0] conv4_sample_in,
   input  wire logic                                 conv4_valid_in,
   output logic      [gain_offset_pkg::SAMPLE_W-1:0] conv3_sample_out,
   output logic                                      conv3_valid_out,
   output logic                                      conv3_odd_out,
   output logic      [gain_offset_pkg::SAMPLE_W-1:0] conv4_sample_out,
   output logic                                      conv4_valid_out,
   output logic                                      conv4_odd_out
);
   localparam int SW = gain_offset_pkg::SAMPLE_W;
   localparam int DW = gain_offset_pkg::DATA_W;

   // register file
   logic [DW-1:0] corr_reg_ff [4];   // correction registers 11h..14h
   logic [DW-1:0] ctrl_ff;           // global enables, register 3
   logic [DW-1:0] rdata_ff;          // read data, valid one cycle
   logic [DW-1:0] nxt_rdata;         // read mux
   logic [2:0]    wr_slot;           // decoded write target
   logic [2:0]    rd_slot;           // decoded read target
   logic          scale_en;          // global_scale_enable
   logic          bias_en;           // global_bias_enable

   // per-converter datapath, index 0 is converter 3, 1 is converter 4
   logic signed [SW-1:0] smp_in [2];            // raw sample
   logic                 vld_in [2];            // raw sample strobe
   logic                 odd_next_ff [2];       // parity of next sample
   logic [DW-1:0]        sel_reg [2];           // register for this parity
   logic [gain_offset_pkg::CODE_W-1:0] sel_code [2];  // selected scale code
   logic [gain_offset_pkg::OFF_W-1:0]  sel_off [2];   // selected bias value
   logic [gain_offset_pkg::FACT_W-1:0] rom_q [2];     // factor, stage 1
   logic signed [gain_offset_pkg::DIFF_W-1:0] nxt_diff [2];  // sample - bias
   logic signed [gain_offset_pkg::DIFF_W-1:0] diff_s1_ff [2]; // stage 1
   logic                 vld_s1_ff [2];         // stage 1 strobe
   logic                 odd_s1_ff [2];         // stage 1 parity
   logic                 scale_s1_ff [2];       // stage 1 gain enable
   logic signed [SW-1:0] out_ff [2];            // corrected sample
   logic                 out_vld_ff [2];        // output strobe
   logic                 out_odd_ff [2];        // output parity

   // map an address to a register slot
   function automatic logic [2:0] reg_slot(input logic [gain_offset_pkg::ADDR_W-1:0] a);
      case (a)
         gain_offset_pkg::CONV3_ODD_ADDR: reg_slot = 3'h0;
         gain_offset_pkg::CONV3_EVN_ADDR: reg_slot = 3'h1;
         gain_offset_pkg::CONV4_ODD_ADDR: reg_slot = 3'h2;
         gain_offset_pkg::CONV4_EVN_ADDR: reg_slot = 3'h3;
         gain_offset_pkg::CTRL_ADDR:      reg_slot = gain_offset_pkg::SLOT_CTRL;
         default:                         reg_slot = gain_offset_pkg::SLOT_NONE;
      endcase
   endfunction

   // clamp a scaled value to the signed sample range
   function automatic logic signed [SW-1:0] sat_sample(
      input logic signed [gain_offset_pkg::SHIFT_W-1:0] v);
      if (v > gain_offset_pkg::SHIFT_W'(gain_offset_pkg::SAT_MAX)) begin
         sat_sample = gain_offset_pkg::SAT_MAX;
      end else if (v < gain_offset_pkg::SHIFT_W'(gain_offset_pkg::SAT_MIN)) begin
         sat_sample = gain_offset_pkg::SAT_MIN;
      end else begin
         sat_sample = v[SW-1:0];
      end
   endfunction

   assign wr_slot  = reg_slot(reg_addr);
   assign rd_slot  = reg_slot(reg_addr);
   assign scale_en = ctrl_ff[gain_offset_pkg::SCALE_EN_BIT];
   assign bias_en  = ctrl_ff[gain_offset_pkg::BIAS_EN_BIT];

   assign smp_in[0] = conv3_sample_in;
   assign smp_in[1] = conv4_sample_in;
   assign vld_in[0] = conv3_valid_in;
   assign vld_in[1] = conv4_valid_in;

   // correction registers, one per slot
   genvar r;
   generate
      for (r = 0; r < 4; r++) begin : g_corr
         always_ff @(posedge clk) begin
            if (rst) begin
               corr_reg_ff[r] <= gain_offset_pkg::REG_RESET;
            end else if (reg_wr && wr_slot == 3'(r)) begin
               // bit 10 held at zero whatever is written
               corr_reg_ff[r] <= reg_wdata & gain_offset_pkg::CORR_MASK;
            end
         end
      end
   endgenerate

   // enable register, only two bits implemented
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_ff <= gain_offset_pkg::REG_RESET;
      end else if (reg_wr && wr_slot == gain_offset_pkg::SLOT_CTRL) begin
         ctrl_ff <= reg_wdata & gain_offset_pkg::CTRL_MASK;
      end
   end

   // read mux, unmapped addresses read zero
   always_comb begin
      case (rd_slot)
         3'h0:                       nxt_rdata = corr_reg_ff[0];
         3'h1:                       nxt_rdata = corr_reg_ff[1];
         3'h2:                       nxt_rdata = corr_reg_ff[2];
         3'h3:                       nxt_rdata = corr_reg_ff[3];
         gain_offset_pkg::SLOT_CTRL: nxt_rdata = ctrl_ff;
         default:                    nxt_rdata = gain_offset_pkg::REG_RESET;
      endcase
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_ff <= gain_offset_pkg::REG_RESET;
      end else if (reg_rd) begin
         rdata_ff <= nxt_rdata;
      end else begin
         rdata_ff <= gain_offset_pkg::REG_RESET;
      end
   end

   assign reg_rdata = rdata_ff;

   // two identical correction lanes
   genvar c;
   generate
      for (c = 0; c < 2; c++) begin : g_lane
         logic [gain_offset_pkg::FACT_W-1:0]  factor;   // applied factor
         logic signed [gain_offset_pkg::PROD_W-1:0] prod;  // rounded product

         // parity register picks odd or even settings
         assign sel_reg[c]  = odd_next_ff[c] ? corr_reg_ff[2*c] : corr_reg_ff[2*c+1];
         assign sel_code[c] = sel_reg[c][gain_offset_pkg::GAIN_MSB:gain_offset_pkg::GAIN_LSB];
         assign sel_off[c]  = sel_reg[c][gain_offset_pkg::OFF_MSB:gain_offset_pkg::OFF_LSB];

         // first sample after reset is odd, then alternates
         always_ff @(posedge clk) begin
            if (rst) begin
               odd_next_ff[c] <= 1'b1;
            end else if (vld_in[c]) begin
               odd_next_ff[c] <= ~odd_next_ff[c];
            end
         end

         // code to factor, read lands with stage 1
         gain_factor_rom #(
            .CODE_W (gain_offset_pkg::CODE_W),
            .FACT_W (gain_offset_pkg::FACT_W)
         ) u_rom (
            .clk    (clk),
            .rst    (rst),
            .code   (sel_code[c]),
            .factor (rom_q[c])
         );

         // offset taken before gain so it cancels the raw error
         always_comb begin
            if (bias_en) begin
               // sign-extended, weight of one 14-bit lsb
               nxt_diff[c] = {smp_in[c][SW-1], smp_in[c]}
                  - {{(gain_offset_pkg::DIFF_W-gain_offset_pkg::OFF_W){sel_off[c][9]}},
                     sel_off[c]};
            end else begin
               nxt_diff[c] = {smp_in[c][SW-1], smp_in[c]};
            end
         end

         // stage 1 pipeline
         always_ff @(posedge clk) begin
            if (rst) begin
               vld_s1_ff[c]   <= 1'b0;
               odd_s1_ff[c]   <= 1'b0;
               scale_s1_ff[c] <= 1'b0;
               diff_s1_ff[c]  <= '0;
            end else begin
               vld_s1_ff[c]   <= vld_in[c];
               odd_s1_ff[c]   <= odd_next_ff[c];
               scale_s1_ff[c] <= scale_en;
               diff_s1_ff[c]  <= nxt_diff[c];
            end
         end

         // unity factor when the global gain enable is clear
         assign factor = scale_s1_ff[c] ? rom_q[c] : gain_offset_pkg::UNITY_FACTOR;
         assign prod = diff_s1_ff[c] * $signed({1'b0, factor})
                       + gain_offset_pkg::ROUND_ADD;

         // stage 2, saturate so large gains cannot wrap
         always_ff @(posedge clk) begin
            if (rst) begin
               out_vld_ff[c] <= 1'b0;
               out_odd_ff[c] <= 1'b0;
               out_ff[c]     <= '0;
            end else begin
               out_vld_ff[c] <= vld_s1_ff[c];
               out_odd_ff[c] <= odd_s1_ff[c];
               // drop the fraction bits, then clamp to the sample range
               out_ff[c]     <= sat_sample(
                  prod[gain_offset_pkg::PROD_W-1:gain_offset_pkg::FRAC_W]);
            end
         end
      end
   endgenerate

   assign conv3_sample_out = out_ff[0];
   assign conv3_valid_out  = out_vld_ff[0];
   assign conv3_odd_out    = out_odd_ff[0];
   assign conv4_sample_out = out_ff[1];
   assign conv4_valid_out  = out_vld_ff[1];
   assign conv4_odd_out    = out_odd_ff[1];

   // checks on the register file
   // properties sample registers before the edge that updates them
   reset_clear_a: assert property (@(posedge clk) rst |=> (corr_reg_ff[0] == 16'h0000
         && corr_reg_ff[1] == 16'h0000 && corr_reg_ff[2] == 16'h0000
         && corr_reg_ff[3] == 16'h0000 && ctrl_ff == 16'h0000))
      else $error("fields not zero after reset");

   odd3_write_a: assert property (@(posedge clk) disable iff (rst)
         reg_wr && reg_addr == 8'h11 |=> corr_reg_ff[0] == ($past(reg_wdata) & 16'hFBFF))
      else $error("write to 11h not stored");

   zero_bit_a: assert property (@(posedge clk) disable iff (rst)
         reg_rd && reg_addr == 8'h14 |=> reg_rdata[10] == 1'b0)
      else $error("bit 10 reads as one");

   // only the two enable bits are stored, the rest read zero
   ctrl_write_a: assert property (@(posedge clk) disable iff (rst)
         reg_wr && reg_addr == 8'h03 |=> ctrl_ff == ($past(reg_wdata) & 16'h1100))
      else $error("enable register write not stored");

   // stale read data would look like a second answer
   rdata_idle_a: assert property (@(posedge clk) disable iff (rst)
         !reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data stands without a read");

   // checks on parity selection
   conv3_odd_sel_a: assert property (@(posedge clk) disable iff (rst)
         vld_in[0] && odd_next_ff[0] |-> sel_code[0] == corr_reg_ff[0][15:11])
      else $error("converter 3 odd code misselected");

   conv4_even_sel_a: assert property (@(posedge clk) disable iff (rst)
         vld_in[1] && !odd_next_ff[1] |-> sel_code[1] == corr_reg_ff[3][15:11])
      else $error("converter 4 even code misselected");

   conv4_bias_sel_a: assert property (@(posedge clk) disable iff (rst)
         vld_in[1] && !odd_next_ff[1] |-> sel_off[1] == corr_reg_ff[3][9:0])
      else $error("converter 4 even offset misselected");

   parity_walk_a: assert property (@(posedge clk) disable iff (rst)
         vld_in[0] ##1 vld_in[0] |-> ##2 conv3_odd_out != $past(conv3_odd_out))
      else $error("parity does not alternate");

   // fixed latency, parity travels with its sample
   lane4_latency_a: assert property (@(posedge clk) disable iff (rst)
         vld_in[1] |-> ##2 conv4_valid_out && conv4_odd_out == $past(odd_next_ff[1], 2))
      else $error("converter 4 output late or parity lost");

   // checks on arithmetic
   bias_sub_a: assert property (@(posedge clk) disable iff (rst)
         vld_in[0] && bias_en |=> diff_s1_ff[0] ==
            $past({smp_in[0][13], smp_in[0]}) - $past({{5{sel_off[0][9]}}, sel_off[0]}))
      else $error("offset not subtracted");

   // even samples of converter 3 take the offset held at 12h
   conv3_even_bias_a: assert property (@(posedge clk) disable iff (rst)
         vld_in[0] && !odd_next_ff[0] && bias_en |=> diff_s1_ff[0] ==
            $past({smp_in[0][13], smp_in[0]})
            - $past({{5{corr_reg_ff[1][9]}}, corr_reg_ff[1][9:0]}))
      else $error("converter 3 even offset misselected");

   bias_sign_a: assert property (@(posedge clk) disable iff (rst)
         vld_in[1] && bias_en && sel_off[1] == 10'h3FF |=>
            diff_s1_ff[1] == $past({smp_in[1][13], smp_in[1]}) + 15'sd1)
      else $error("offset not signed");

   bias_off_a: assert property (@(posedge clk) disable iff (rst)
         vld_in[0] && !bias_en |=> diff_s1_ff[0] == $past({smp_in[0][13], smp_in[0]}))
      else $error("offset applied while disabled");

   gain_bypass_a: assert property (@(posedge clk) disable iff (rst)
         vld_in[1] && ctrl_ff == 16'h0000 |-> ##2
            conv4_valid_out && conv4_sample_out == $past(smp_in[1], 2))
      else $error("sample altered with corrections off");

   gain_zero_a: assert property (@(posedge clk) disable iff (rst)
         vld_in[0] && scale_en && !bias_en && sel_code[0] == 5'h00 |-> ##2
            conv3_sample_out == $past(smp_in[0], 2))
      else $error("code zero is not unity gain");
endmodule

//--- logic/gain_offset_pkg.sv
// shared constants for the per-sample gain and offset correction block
package gain_offset_pkg;
   // register port geometry
   localparam int ADDR_W = 8;                      // register address width
   localparam int DATA_W = 16;                     // register data width

   // register offsets
   localparam logic [ADDR_W-1:0] CTRL_ADDR      = 8'h03;  // global enables
   localparam logic [ADDR_W-1:0] CONV3_ODD_ADDR = 8'h11;  // conv3_odd_gain_offset
   localparam logic [ADDR_W-1:0] CONV3_EVN_ADDR = 8'h12;  // conv3_even_gain_offset
   localparam logic [ADDR_W-1:0] CONV4_ODD_ADDR = 8'h13;  // conv4_odd_gain_offset
   localparam logic [ADDR_W-1:0] CONV4_EVN_ADDR = 8'h14;  // conv4_even_gain_offset

   // decoded register slots
   localparam logic [2:0] SLOT_CTRL = 3'h4;        // control register slot
   localparam logic [2:0] SLOT_NONE = 3'h7;        // unmapped address

   // correction register field layout
   localparam int GAIN_MSB = 15;                   // scale code top bit
   localparam int GAIN_LSB = 11;                   // scale code bottom bit
   localparam int ZERO_BIT = 10;                   // must stay zero
   localparam int OFF_MSB  = 9;                    // bias value top bit
   localparam int OFF_LSB  = 0;                    // bias value bottom bit
   localparam logic [DATA_W-1:0] CORR_MASK = 16'hFBFF;  // writable bits

   // control register field layout
   localparam int SCALE_EN_BIT = 12;               // global_scale_enable
   localparam int BIAS_EN_BIT  = 8;                // global_bias_enable
   localparam logic [DATA_W-1:0] CTRL_MASK = 16'h1100;  // implemented bits

   // reset values
   localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;  // all fields zero

   // datapath widths
   localparam int SAMPLE_W = 14;                   // sample width, 14-bit lsb
   localparam int CODE_W   = 5;                    // scale code width
   localparam int OFF_W    = 10;                   // bias value width
   localparam int DIFF_W   = 15;                   // sample minus bias
   localparam int FACT_W   = 16;                   // linear factor, unsigned
   localparam int FRAC_W   = 14;                   // factor fraction bits
   localparam int PROD_W   = 32;                   // product width
   localparam int SHIFT_W  = PROD_W - FRAC_W;      // product after scaling

   // gain constants
   localparam logic [FACT_W-1:0] UNITY_FACTOR = 16'h4000;      // 0 dB
   localparam logic signed [PROD_W-1:0] ROUND_ADD = 32'sh00002000; // half lsb
   localparam logic signed [SAMPLE_W-1:0] SAT_MAX = 14'sh1FFF;
   localparam logic signed [SAMPLE_W-1:0] SAT_MIN = 14'sh2000;

   // sample timing
   localparam int LATENCY = 2;                     // input to output cycles
endpackage

//--- logic/gain_factor_rom.sv
// lookup of linear gain factors in steps of 0.2 dB, registered read
`timescale 1ns/100ps
module gain_factor_rom #(
   parameter int CODE_W = 5,
   parameter int FACT_W = 16
)(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic [CODE_W-1:0] code,
   output logic      [FACT_W-1:0] factor
);
   logic [FACT_W-1:0] factor_ff;   // registered read data
   logic [FACT_W-1:0] nxt_factor;  // table lookup

   // 16384 * 10^(n*0.2/20), rounded to nearest
   always_comb begin
      case (code)
         5'h00: nxt_factor = 16'h4000;
         5'h01: nxt_factor = 16'h417E;
         5'h02: nxt_factor = 16'h4304;
         5'h03: nxt_factor = 16'h4494;
         5'h04: nxt_factor = 16'h462D;
         5'h05: nxt_factor = 16'h47CF;
         5'h06: nxt_factor = 16'h497B;
         5'h07: nxt_factor = 16'h4B32;
         5'h08: nxt_factor = 16'h4CF2;
         5'h09: nxt_factor = 16'h4EBD;
         5'h0A: nxt_factor = 16'h5092;
         5'h0B: nxt_factor = 16'h5273;
         5'h0C: nxt_factor = 16'h545E;
         5'h0D: nxt_factor = 16'h5655;
         5'h0E: nxt_factor = 16'h5858;
         5'h0F: nxt_factor = 16'h5A67;
         5'h10: nxt_factor = 16'h5C82;
         5'h11: nxt_factor = 16'h5EAA;
         5'h12: nxt_factor = 16'h60DE;
         5'h13: nxt_factor = 16'h6320;
         5'h14: nxt_factor = 16'h656F;
         5'h15: nxt_factor = 16'h67CC;
         5'h16: nxt_factor = 16'h6A37;
         5'h17: nxt_factor = 16'h6CB0;
         5'h18: nxt_factor = 16'h6F38;
         5'h19: nxt_factor = 16'h71CF;
         5'h1A: nxt_factor = 16'h7476;
         5'h1B: nxt_factor = 16'h772C;
         5'h1C: nxt_factor = 16'h79F3;
         5'h1D: nxt_factor = 16'h7CCA;
         5'h1E: nxt_factor = 16'h7FB2;
         5'h1F: nxt_factor = 16'h82AC;
         default: nxt_factor = 16'h4000;  // unreachable for 5-bit code
      endcase
   end

   // read data from a register, unity after reset
   always_ff @(posedge clk) begin
      if (rst) begin
         factor_ff <= 16'h4000;
      end else begin
         factor_ff <= nxt_factor;
      end
   end

   assign factor = factor_ff;
endmodule

//--- testbench/converter_model.sv
// converter core model feeding one raw sample stream into the correction block
`timescale 1ns/100ps
module converter_model (
   input  wire logic                                 clk,
   input  wire logic                                 rst,
   input  wire logic                                 run,
   input  wire logic                                 slow,
   input  wire logic [15:0]                          word,
   output logic      [gain_offset_pkg::SAMPLE_W-1:0] sample,
   output logic                                      valid
);
   logic [gain_offset_pkg::SAMPLE_W-1:0] sample_ff;  // sample on the bus
   logic                                 valid_ff;   // sample strobe

   // prompt: one sample every cycle; slow: gaps where word bit 15 is low.
   // between samples the bus inverts every cycle, so stale data shows again only after an even number of idle cycles
   always_ff @(posedge clk) begin
      if (rst) begin
         valid_ff  <= 1'b0;
         sample_ff <= '0;
      end else if (run && (!slow || word[15])) begin
         valid_ff  <= 1'b1;
         sample_ff <= word[gain_offset_pkg::SAMPLE_W-1:0];
      end else begin
         valid_ff  <= 1'b0;
         sample_ff <= ~sample_ff;
      end
   end

   assign sample = sample_ff;
   assign valid  = valid_ff;
endmodule

//--- testbench/tb.sv
// self-checking bench for the per-sample gain and offset correction block
`timescale 1ns/100ps
module tb;
   typedef struct {int c; logic odd; logic [13:0] v;} exp_t;
   logic        clk, rst, reg_wr, reg_rd, run, slow;   // clock, reset, strobes, stream control
   logic [7:0]  reg_addr;                              // register address
   logic [15:0] reg_wdata, reg_rdata, word3, word4;    // bus data and raw stream words
   logic [13:0] s3_in, s4_in, s3_out, s4_out;          // samples
   logic        v3_in, v4_in, v3_out, v4_out, o3, o4;  // strobes and parity
   logic [15:0] shadow [4];                            // expected register contents
   logic [15:0] ctl;                                   // expected enable register
   logic [7:0]  addrs [4];                             // correction register offsets
   logic        par [2];                               // next sample parity per converter
   exp_t        q [2][$];                              // pending expected outputs
   logic [31:0] xs_state = 32'd59232;                  // random generator state
   int          mismatches, checked, cyc;

   per_sample_gain_offset_correction per_sample_gain_offset_correction_inst (
      .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv3_sample_in(s3_in),
      .conv3_valid_in(v3_in), .conv4_sample_in(s4_in), .conv4_valid_in(v4_in),
      .conv3_sample_out(s3_out), .conv3_valid_out(v3_out), .conv3_odd_out(o3),
      .conv4_sample_out(s4_out), .conv4_valid_out(v4_out), .conv4_odd_out(o4));
   converter_model conv3_model (.clk(clk), .rst(rst), .run(run), .slow(slow), .word(word3),
      .sample(s3_in), .valid(v3_in));
   converter_model conv4_model (.clk(clk), .rst(rst), .run(run), .slow(slow), .word(word4),
      .sample(s4_in), .valid(v4_in));

   // xorshift generator, fixed seed so every run repeats
   function automatic logic [31:0] xs();
      xs_state = xs_state ^ (xs_state << 13);
      xs_state = xs_state ^ (xs_state >> 17);
      xs_state = xs_state ^ (xs_state << 5);
      return xs_state;
   endfunction

   // raw word with full-scale samples mixed in to reach saturation
   function automatic logic [15:0] pick();
      logic [15:0] w;
      w = xs();
      if (w[10:8] == 3'h0) w[13:0] = w[0] ? 14'h1FFF : 14'h2000;
      return w;
   endfunction

   // expected output: subtract signed offset, scale by 10^(n/100), round, saturate
   function automatic logic [13:0] exp_out(logic [13:0] s, logic [15:0] r, logic [15:0] c);
      longint d, g, p;
      d = longint'($signed(s));
      if (c[gain_offset_pkg::BIAS_EN_BIT]) d = d - longint'($signed(r[9:0]));
      g = 16384;
      if (c[gain_offset_pkg::SCALE_EN_BIT]) g = $rtoi(16384.0 * (10.0 ** (r[15:11] * 0.01)) + 0.5);
      p = (d * g + 8192) >>> 14;
      if (p > 8191) p = 8191;
      if (p < -8192) p = -8192;
      return p[13:0];
   endfunction

   task automatic check(input logic ok, input string m);
      checked++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask

   task automatic complete_run();
      $display("comparisons %0d, mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask

   // read data must stand in the cycle after the strobe only
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1;
      check(reg_rdata === e, "read data");
      @(posedge clk);
      #1;
      check(reg_rdata === 16'h0000, "read data not cleared");
   endtask

   // scoreboard for one converter, sampled mid-cycle where signals are settled
   task automatic watch(input int k, input logic vi, input logic [13:0] si, input logic vo,
                        input logic oo, input logic [13:0] so);
      exp_t e;
      if (vo) begin
         if (q[k].size() == 0) check(1'b0, "output with no sample in");
         else begin
            e = q[k].pop_front();
            check(cyc == e.c + gain_offset_pkg::LATENCY, "latency");
            check(oo === e.odd, "parity");
            check(so === e.v, "corrected sample");
         end
      end
      if (vi) begin
         e.c   = cyc;
         e.odd = par[k];
         e.v   = exp_out(si, shadow[2 * k + (par[k] ? 0 : 1)], ctl);
         q[k].push_back(e);
         par[k] = !par[k];
      end
   endtask

   always @(negedge clk) begin
      if (rst) begin
         par = '{1'b1, 1'b1};
         // registers return to zero with the block
         shadow = '{default: 16'h0000};
         ctl = 16'h0000;
         q[0].delete();
         q[1].delete();
      end else begin
         cyc++;
         watch(0, v3_in, s3_in, v3_out, o3, s3_out);
         watch(1, v4_in, s4_in, v4_out, o4, s4_out);
      end
   end

   // raw words for both converters, fresh every cycle
   always @(posedge clk) begin
      word3 <= pick();
      word4 <= pick();
   end

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // watchdog: the sequence needs about 2100 cycles
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      complete_run();
   end

   initial begin
      logic [15:0] d;
      {reg_wr, reg_rd, run, slow, reg_addr, reg_wdata, word3, word4} = '0;
      rst = 1'b1;
      addrs = '{gain_offset_pkg::CONV3_ODD_ADDR, gain_offset_pkg::CONV3_EVN_ADDR,
                gain_offset_pkg::CONV4_ODD_ADDR, gain_offset_pkg::CONV4_EVN_ADDR};
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      // every field starts at zero
      for (int i = 0; i < 4; i++) rd(addrs[i], 16'h0000);
      rd(gain_offset_pkg::CTRL_ADDR, 16'h0000);
      $display("test reset values done");
      // all ones: bit 10 reads zero, unmapped place ignored
      for (int i = 0; i < 4; i++) wr(addrs[i], 16'hFFFF);
      wr(8'h20, 16'hFFFF);
      for (int i = 0; i < 4; i++) rd(addrs[i], 16'hFBFF);
      rd(8'h20, 16'h0000);
      $display("test register access done");
      // each enable combination, corner fields first, then random ones
      for (int r = 0; r < 12; r++) begin
         for (int i = 0; i < 4; i++) begin
            // conv4 even gets offset -1 to reach the sign corner
            d = (r < 4) ? ((i == 3) ? 16'h03FF : (i % 2) ? 16'h0200 : 16'hFDFF) : xs();
            wr(addrs[i], d);
            shadow[i] = d & gain_offset_pkg::CORR_MASK;
         end
         d = xs();
         d[12] = r[1];
         d[8] = r[0];
         wr(gain_offset_pkg::CTRL_ADDR, d);
         ctl = d & gain_offset_pkg::CTRL_MASK;
         rd(gain_offset_pkg::CTRL_ADDR, ctl);
         slow <= r[2];
         run <= 1'b1;
         repeat (150) @(posedge clk);
         run <= 1'b0;
         repeat (6) @(posedge clk);
         check(q[0].size() == 0 && q[1].size() == 0, "samples lost");
      end
      $display("test streaming done");
      // reset while streaming: fields back to zero, parity restarts odd
      run <= 1'b1;
      repeat (20) @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 4; i++) rd(addrs[i], 16'h0000);
      rd(gain_offset_pkg::CTRL_ADDR, 16'h0000);
      run <= 1'b0;
      repeat (6) @(posedge clk);
      check(q[0].size() == 0 && q[1].size() == 0, "samples lost");
      $display("test second reset done");
      complete_run();
   end
endmodule
